/* rtl/ecr_apb_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ecr_apb_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ecr_pkg::ECR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stored register values
  output logic [7:0] enh_one_reg,
  output logic [7:0] enh_two_reg,
  output logic [7:0] enh_three_reg
);
  import ecr_pkg::*;

  logic hit_one;
  logic hit_two;
  logic hit_three;
  logic hit;
  logic commit;
  logic [7:0] rd_byte;

  // Address decode and read mux
  assign hit_one = (paddr == ECR_ADDR_ENH_ONE);
  assign hit_two = (paddr == ECR_ADDR_ENH_TWO);
  assign hit_three = (paddr == ECR_ADDR_ENH_THREE);
  assign hit = hit_one | hit_two | hit_three;
  assign commit = psel & penable & pready;
  assign rd_byte = hit_one ? enh_one_reg : hit_two ? enh_two_reg : hit_three ? enh_three_reg : 8'h00;

  // One wait state, then the answer with data and error flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= {24'h00_0000, rd_byte};
        pslverr <= ~hit;
      end
    end
  end

  // Register writes land on the completing edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enh_one_reg <= ECR_RST_ENH_ONE;
      enh_two_reg <= ECR_RST_ENH_TWO;
      enh_three_reg <= ECR_RST_ENH_THREE;
    end else if (commit & pwrite) begin
      if (hit_one) enh_one_reg <= pwdata[7:0];
      if (hit_two) enh_two_reg <= pwdata[7:0] & ECR_ENH_TWO_WMASK;
      if (hit_three) enh_three_reg <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Completing read of the second register shows the stored byte, upper bits zero
  property p_readback;
    psel && penable && pready && !pwrite && hit_two |-> prdata == {24'h00_0000, enh_two_reg};
  endproperty
  a_readback: assert property (p_readback) else $error("read does not return last write");

  // Completing write lands with the reserved bits dropped
  property p_write_mask;
    psel && penable && pready && pwrite && hit_two
      |=> enh_two_reg == (ECR_ENH_TWO_WMASK & $past(pwdata[7:0]));
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("second register write not stored");

endmodule : ecr_apb_regs
`default_nettype wire

/* rtl/ecr_pkg.sv */
package ecr_pkg;

  // Register indices as printed and their word-aligned byte addresses
  localparam int ECR_ADDR_W = 12;
  localparam logic [7:0] ECR_IDX_ENH_ONE = 8'he0;
  localparam logic [7:0] ECR_IDX_ENH_TWO = 8'he1;
  localparam logic [7:0] ECR_IDX_ENH_THREE = 8'he2;
  localparam logic [ECR_ADDR_W-1:0] ECR_ADDR_ENH_ONE = {2'h0, ECR_IDX_ENH_ONE, 2'h0};
  localparam logic [ECR_ADDR_W-1:0] ECR_ADDR_ENH_TWO = {2'h0, ECR_IDX_ENH_TWO, 2'h0};
  localparam logic [ECR_ADDR_W-1:0] ECR_ADDR_ENH_THREE = {2'h0, ECR_IDX_ENH_THREE, 2'h0};

  // Values after reset: every enhancement off
  localparam logic [7:0] ECR_RST_ENH_ONE = 8'h00;
  localparam logic [7:0] ECR_RST_ENH_TWO = 8'h00;
  localparam logic [7:0] ECR_RST_ENH_THREE = 8'h00;
  localparam logic [7:0] ECR_ENH_TWO_WMASK = 8'h1f;

  // Bit positions, first register
  localparam int ECR_B1_GLOBAL = 7;
  localparam int ECR_B1_SUSP_DLY = 6;
  localparam int ECR_B1_LCD_STRETCH = 5;
  localparam int ECR_B1_NARROW_CARD = 4;
  localparam int ECR_B1_CARD_CHANGE = 3;
  localparam int ECR_B1_CARD_SPACE = 2;
  localparam int ECR_B1_CARD_PRESENT = 1;
  localparam int ECR_B1_WIDE_DRAM = 0;
  // Bit positions, second register
  localparam int ECR_B2_DBUS_GATE = 4;
  localparam int ECR_B2_PSRAM_OE = 3;
  localparam int ECR_B2_ROM_DOZE = 2;
  localparam int ECR_B2_ATA = 1;
  localparam int ECR_B2_CARD_MASK = 0;
  // Bit positions, third register
  localparam int ECR_B3_GLOBAL = 7;
  localparam int ECR_B3_FAST_OFF = 6;
  localparam int ECR_B3_BAUD_PIN = 5;
  localparam int ECR_B3_ARB_RST = 4;
  localparam int ECR_B3_SOFT_SEQ = 3;
  localparam int ECR_B3_LOGIC_PWR = 2;
  localparam int ECR_B3_SIGNAL_EN = 1;
  localparam int ECR_B3_BIAS_PWR = 0;

  // Timing
  localparam int ECR_CLK_PERIOD_NS = 8;
  localparam int ECR_ATA_SAMPLE_NS = 55;
  localparam int ECR_ATA_SAMPLE_CYC = (ECR_ATA_SAMPLE_NS + ECR_CLK_PERIOD_NS - 1) / ECR_CLK_PERIOD_NS;
  localparam int ECR_SUSP_DELAY_CYC = 4;
  localparam int ECR_CNT_W = 4;
  localparam logic [2:0] ECR_PANEL_OFF_CODE = 3'h7;

  // Clock-stopped doze sequencer states
  typedef enum logic [2:0] {
    ECR_ST_RUN = 3'h1,
    ECR_ST_WAIT_ROM = 3'h2,
    ECR_ST_STOP = 3'h4
  } ecr_doze_e;

endpackage : ecr_pkg

/* rtl/ecr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ecr_top #(
  parameter int SUSPEND_DELAY_CYC = ecr_pkg::ECR_SUSP_DELAY_CYC,
  parameter int ATA_SAMPLE_CYC = ecr_pkg::ECR_ATA_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ecr_pkg::ECR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power management state
  input wire logic pm_suspend_req,
  input wire logic pm_doze,
  input wire logic pm_sleep,
  input wire logic pm_suspend_state,
  input wire logic pm_off_state,
  input wire logic static_doze_mode,
  output logic suspend_enter,
  output logic cpu_clk_run,
  // Display memory cycle
  input wire logic lcd_cycle_done,
  output logic lcd_cycle_end,
  // Fix enables toward patched controllers
  output logic narrow_card_support,
  output logic card_change_fix,
  output logic card_space_fix,
  output logic card_present_fix,
  output logic wide_dram_fix,
  output logic psram_oe_fix,
  output logic ata_timing_relaxed,
  output logic card_mask_ctrl_en,
  output logic arbiter_reset_out,
  // Data bus inputs
  input wire logic [15:0] cpu_data_in,
  output logic [15:0] cpu_data_gated,
  // ROM selects
  input wire logic rom_req_0_n,
  input wire logic rom_req_1_n,
  output logic rom_select_0_n,
  output logic rom_select_1_n,
  // Card width sampling
  input wire logic card_cs_active,
  input wire logic card_io_width16,
  output logic card_io_width16_sampled,
  // General pin three
  input wire logic gpio_pin_three_mode_out,
  input wire logic gpio_pin_three_mode_oe,
  input wire logic baud_clock_out,
  output logic gpio_pin_three_out,
  output logic gpio_pin_three_oe,
  // Panel power
  input wire logic lcd_mode_delay_wr,
  input wire logic [2:0] lcd_mode_delay_val,
  input wire logic hw_logic_power,
  input wire logic hw_if_enable,
  input wire logic hw_bias_power,
  output logic panel_logic_power_out,
  output logic panel_logic_power_oe,
  output logic panel_bias_power_out,
  output logic panel_bias_power_oe,
  output logic panel_if_enable,
  output logic panel_hw_powerup_start
);
  import ecr_pkg::*;

  // Elaboration check on counter reach
  if (SUSPEND_DELAY_CYC < 1 || SUSPEND_DELAY_CYC >= (1 << ECR_CNT_W) ||
      ATA_SAMPLE_CYC < 1 || ATA_SAMPLE_CYC >= (1 << ECR_CNT_W)) begin : g_bad_param
    $error("ecr_top: delay counts out of counter range");
  end

  localparam logic [ECR_CNT_W-1:0] SUSP_LAST = ECR_CNT_W'(SUSPEND_DELAY_CYC);
  localparam logic [ECR_CNT_W-1:0] ATA_LAST = ECR_CNT_W'(ATA_SAMPLE_CYC);

  logic [7:0] enh_one_reg;
  logic [7:0] enh_two_reg;
  logic [7:0] enh_three_reg;
  logic glob;
  logic bank3;
  logic eff_susp;
  logic eff_stretch;
  logic eff_dbus;
  logic eff_rom;
  logic eff_ata;
  logic eff_fast;
  logic eff_baud;
  logic eff_soft;
  logic [ECR_CNT_W-1:0] susp_cnt_reg;
  logic lcd_stretch_reg;
  ecr_doze_e doze_reg;
  ecr_doze_e doze_next;
  logic doze_req;
  logic [ECR_CNT_W-1:0] cs_cnt_reg;
  logic [ECR_CNT_W-1:0] cs_sample_at;
  logic fast_off_reg;
  logic fast_off_next;
  logic delay_value_wr;

  // Register bank over APB
  ecr_apb_regs u_regs (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .enh_one_reg(enh_one_reg),
    .enh_two_reg(enh_two_reg),
    .enh_three_reg(enh_three_reg)
  );

  // Effective enables: everything behind the first global bit
  assign glob = enh_one_reg[ECR_B1_GLOBAL];
  assign bank3 = glob & enh_three_reg[ECR_B3_GLOBAL];
  assign eff_susp = glob & enh_one_reg[ECR_B1_SUSP_DLY];
  assign eff_stretch = glob & enh_one_reg[ECR_B1_LCD_STRETCH];
  assign eff_dbus = glob & enh_two_reg[ECR_B2_DBUS_GATE];
  assign eff_rom = glob & enh_two_reg[ECR_B2_ROM_DOZE];
  assign eff_ata = glob & enh_two_reg[ECR_B2_ATA];
  assign eff_fast = bank3 & enh_three_reg[ECR_B3_FAST_OFF];
  assign eff_baud = bank3 & enh_three_reg[ECR_B3_BAUD_PIN];
  assign eff_soft = bank3 & enh_three_reg[ECR_B3_SOFT_SEQ];

  // Level enables handed to the patched controllers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      narrow_card_support <= 1'b0;
      card_change_fix <= 1'b0;
      card_space_fix <= 1'b0;
      card_present_fix <= 1'b0;
      wide_dram_fix <= 1'b0;
      psram_oe_fix <= 1'b0;
      ata_timing_relaxed <= 1'b0;
      card_mask_ctrl_en <= 1'b0;
      arbiter_reset_out <= 1'b0;
    end else begin
      narrow_card_support <= glob & enh_one_reg[ECR_B1_NARROW_CARD];
      card_change_fix <= glob & enh_one_reg[ECR_B1_CARD_CHANGE];
      card_space_fix <= glob & enh_one_reg[ECR_B1_CARD_SPACE];
      card_present_fix <= glob & enh_one_reg[ECR_B1_CARD_PRESENT];
      wide_dram_fix <= glob & enh_one_reg[ECR_B1_WIDE_DRAM];
      psram_oe_fix <= glob & enh_two_reg[ECR_B2_PSRAM_OE];
      ata_timing_relaxed <= eff_ata;
      card_mask_ctrl_en <= glob & enh_two_reg[ECR_B2_CARD_MASK];
      arbiter_reset_out <= bank3 & enh_three_reg[ECR_B3_ARB_RST];
    end
  end

  // Suspend entry, optionally held off by a fixed count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      susp_cnt_reg <= '0;
      suspend_enter <= 1'b0;
    end else begin
      if (!pm_suspend_req) begin
        susp_cnt_reg <= '0;
      end else if (susp_cnt_reg != SUSP_LAST) begin
        susp_cnt_reg <= susp_cnt_reg + 1'b1;
      end
      suspend_enter <= pm_suspend_req & (~eff_susp | (susp_cnt_reg == SUSP_LAST));
    end
  end

  // Display cycle end, one extra cycle when stretched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lcd_stretch_reg <= 1'b0;
      lcd_cycle_end <= 1'b0;
    end else begin
      lcd_stretch_reg <= lcd_cycle_done;
      lcd_cycle_end <= eff_stretch ? lcd_stretch_reg : lcd_cycle_done;
    end
  end

  // Clock-stopped doze: waits for idle ROM selects when that control is on
  assign doze_req = static_doze_mode & (pm_doze | pm_sleep);
  always_comb begin
    doze_next = doze_reg;
    case (doze_reg)
      ECR_ST_RUN: begin
        if (doze_req) begin
          if (eff_rom && !(rom_req_0_n && rom_req_1_n)) doze_next = ECR_ST_WAIT_ROM;
          else doze_next = ECR_ST_STOP;
        end
      end
      ECR_ST_WAIT_ROM: begin
        if (!doze_req) doze_next = ECR_ST_RUN;
        else if (!eff_rom || (rom_req_0_n && rom_req_1_n)) doze_next = ECR_ST_STOP;
      end
      ECR_ST_STOP: begin
        if (!doze_req) doze_next = ECR_ST_RUN;
      end
      default: doze_next = ECR_ST_RUN;
    endcase
  end

  // Doze state, clock run and ROM select outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doze_reg <= ECR_ST_RUN;
      cpu_clk_run <= 1'b1;
      rom_select_0_n <= 1'b1;
      rom_select_1_n <= 1'b1;
    end else begin
      doze_reg <= doze_next;
      cpu_clk_run <= (doze_next != ECR_ST_STOP);
      rom_select_0_n <= rom_req_0_n | (eff_rom & (doze_next == ECR_ST_STOP));
      rom_select_1_n <= rom_req_1_n | (eff_rom & (doze_next == ECR_ST_STOP));
    end
  end

  // Data bus input gating while the clock is stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_data_gated <= 16'h0000;
    end else if (eff_dbus && doze_next == ECR_ST_STOP) begin
      cpu_data_gated <= 16'h0000;
    end else begin
      cpu_data_gated <= cpu_data_in;
    end
  end

  // Card width sample point counted from card select
  assign cs_sample_at = eff_ata ? ATA_LAST - 1'b1 : '0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_cnt_reg <= '0;
      card_io_width16_sampled <= 1'b0;
    end else begin
      if (!card_cs_active) begin
        cs_cnt_reg <= '0;
      end else if (cs_cnt_reg != ATA_LAST) begin
        cs_cnt_reg <= cs_cnt_reg + 1'b1;
      end
      if (card_cs_active && cs_cnt_reg == cs_sample_at) begin
        card_io_width16_sampled <= card_io_width16;
      end
    end
  end

  // General pin three: baud clock override, floated in suspend and off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_pin_three_out <= 1'b0;
      gpio_pin_three_oe <= 1'b0;
    end else if (pm_suspend_state || pm_off_state) begin
      gpio_pin_three_out <= 1'b0;
      gpio_pin_three_oe <= 1'b0;
    end else if (eff_baud) begin
      gpio_pin_three_out <= baud_clock_out;
      gpio_pin_three_oe <= 1'b1;
    end else begin
      gpio_pin_three_out <= gpio_pin_three_mode_out;
      gpio_pin_three_oe <= gpio_pin_three_mode_oe;
    end
  end

  // Fast panel off: code 111 drops power, another value restarts hardware
  assign delay_value_wr = lcd_mode_delay_wr & (lcd_mode_delay_val != ECR_PANEL_OFF_CODE);
  always_comb begin
    fast_off_next = fast_off_reg;
    if (!eff_fast || eff_soft) begin
      fast_off_next = 1'b0;
    end else if (lcd_mode_delay_wr) begin
      fast_off_next = (lcd_mode_delay_val == ECR_PANEL_OFF_CODE);
    end
  end

  // Fast off state and hardware power-up trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_off_reg <= 1'b0;
      panel_hw_powerup_start <= 1'b0;
    end else begin
      fast_off_reg <= fast_off_next;
      panel_hw_powerup_start <= fast_off_reg & eff_fast & ~eff_soft & delay_value_wr;
    end
  end

  // Panel power pins: software bits, forced off, or hardware sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panel_logic_power_out <= 1'b0;
      panel_logic_power_oe <= 1'b0;
      panel_bias_power_out <= 1'b0;
      panel_bias_power_oe <= 1'b0;
      panel_if_enable <= 1'b0;
    end else if (eff_soft) begin
      panel_logic_power_out <= enh_three_reg[ECR_B3_LOGIC_PWR];
      panel_logic_power_oe <= enh_three_reg[ECR_B3_LOGIC_PWR];
      panel_if_enable <= enh_three_reg[ECR_B3_SIGNAL_EN];
      panel_bias_power_out <= enh_three_reg[ECR_B3_BIAS_PWR];
      panel_bias_power_oe <= enh_three_reg[ECR_B3_BIAS_PWR];
    end else if (fast_off_next) begin
      panel_logic_power_out <= 1'b0;
      panel_logic_power_oe <= 1'b0;
      panel_if_enable <= 1'b0;
      panel_bias_power_out <= 1'b0;
      panel_bias_power_oe <= 1'b0;
    end else begin
      panel_logic_power_out <= hw_logic_power;
      panel_logic_power_oe <= hw_logic_power;
      panel_if_enable <= hw_if_enable;
      panel_bias_power_out <= hw_bias_power;
      panel_bias_power_oe <= hw_bias_power;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Suspend hold-off and release
  sequence s_susp_start;
    eff_susp && $rose(pm_suspend_req);
  endsequence
  property p_susp_hold;
    s_susp_start ##1 (eff_susp && pm_suspend_req)[*3] |-> !suspend_enter;
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("suspend entered too early");
  property p_susp_go;
    s_susp_start ##1 (eff_susp && pm_suspend_req)[*4] |=> suspend_enter;
  endproperty
  a_susp_go: assert property (p_susp_go) else $error("delayed suspend never entered");

  property p_global_off;
    !glob |=> !narrow_card_support && !card_change_fix && !ata_timing_relaxed
      && !arbiter_reset_out && !card_mask_ctrl_en && !wide_dram_fix;
  endproperty
  a_global_off: assert property (p_global_off) else $error("enhancement active without global bit");

  property p_lcd_stretch;
    eff_stretch && lcd_cycle_done ##1 eff_stretch |=> lcd_cycle_end;
  endproperty
  a_lcd_stretch: assert property (p_lcd_stretch) else $error("stretched cycle end missing");

  property p_doze_stop;
    doze_req && doze_reg != ECR_ST_STOP && (!eff_rom || (rom_req_0_n && rom_req_1_n)) |=> !cpu_clk_run;
  endproperty
  a_doze_stop: assert property (p_doze_stop) else $error("clock not halted on doze entry");

  property p_rom_quiet;
    !cpu_clk_run && $past(eff_rom) |-> rom_select_0_n && rom_select_1_n;
  endproperty
  a_rom_quiet: assert property (p_rom_quiet) else $error("ROM select active with clock stopped");

  property p_dbus_gate;
    !cpu_clk_run && $past(eff_dbus) |-> cpu_data_gated == 16'h0000;
  endproperty
  a_dbus_gate: assert property (p_dbus_gate) else $error("data inputs not gated in doze");

  sequence s_ata_window;
    eff_ata && $rose(card_cs_active) ##1 (eff_ata && card_cs_active)[*6];
  endsequence
  property p_ata_sample;
    s_ata_window |=> card_io_width16_sampled == $past(card_io_width16);
  endproperty
  a_ata_sample: assert property (p_ata_sample) else $error("width not sampled at 55 ns");

  property p_gpio_float;
    pm_suspend_state || pm_off_state |=> !gpio_pin_three_oe;
  endproperty
  a_gpio_float: assert property (p_gpio_float) else $error("pin three driven in suspend");

  property p_baud_pin;
    eff_baud && !pm_suspend_state && !pm_off_state
      |=> gpio_pin_three_oe && gpio_pin_three_out == $past(baud_clock_out);
  endproperty
  a_baud_pin: assert property (p_baud_pin) else $error("baud clock not on pin three");

  property p_fast_off;
    eff_fast && !eff_soft && lcd_mode_delay_wr && lcd_mode_delay_val == ECR_PANEL_OFF_CODE
      |=> !panel_logic_power_oe && !panel_bias_power_oe && !panel_if_enable;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("panel not powered down at once");

  property p_soft_seq;
    eff_soft |=> panel_logic_power_oe == $past(enh_three_reg[ECR_B3_LOGIC_PWR])
      && panel_if_enable == $past(enh_three_reg[ECR_B3_SIGNAL_EN])
      && panel_bias_power_oe == $past(enh_three_reg[ECR_B3_BIAS_PWR]);
  endproperty
  a_soft_seq: assert property (p_soft_seq) else $error("panel pins ignore software bits");

endmodule : ecr_top
`default_nettype wire

/* tb/ecr_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ecr_top_test;
  import ecr_pkg::*;
  localparam int SDLY = 4;
  // Driven inputs and observed outputs
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, suspend_enter, cpu_clk_run, lcd_cycle_end;
  logic pm_suspend_req = 1'b0, pm_doze = 1'b0, pm_sleep = 1'b0, pm_suspend_state = 1'b0;
  logic pm_off_state = 1'b0, static_doze_mode = 1'b0, lcd_cycle_done = 1'b0;
  logic narrow_card_support, card_change_fix, card_space_fix, card_present_fix, wide_dram_fix;
  logic psram_oe_fix, ata_timing_relaxed, card_mask_ctrl_en, arbiter_reset_out;
  logic [15:0] cpu_data_in = 16'h0, cpu_data_gated;
  logic rom_req_0_n = 1'b1, rom_req_1_n = 1'b1, rom_select_0_n, rom_select_1_n;
  logic card_cs_active = 1'b0, card_io_width16 = 1'b0, card_io_width16_sampled;
  logic gpio_pin_three_mode_out = 1'b0, gpio_pin_three_mode_oe = 1'b0, baud_clock_out = 1'b0;
  logic gpio_pin_three_out, gpio_pin_three_oe, lcd_mode_delay_wr = 1'b0;
  logic [2:0] lcd_mode_delay_val = 3'h0;
  logic hw_logic_power = 1'b0, hw_if_enable = 1'b0, hw_bias_power = 1'b0;
  logic panel_logic_power_out, panel_logic_power_oe, panel_bias_power_out, panel_bias_power_oe;
  logic panel_if_enable, panel_hw_powerup_start;
  int bad_count = 0;
  int samples_checked = 0;

  ecr_top #(.SUSPEND_DELAY_CYC(SDLY), .ATA_SAMPLE_CYC(7)) i_dut (.*);

  // Free-running bench clock, 8 ns period
  always #4 clk = ~clk;

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  // Let k edges pass, then step clear of the edge
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("BAD apb pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask : rdchk

  // Edges from stimulus until the watched output is seen high
  task automatic lat(input logic sel, input int e);
    int k = 0;
    do begin
      @(posedge clk);
      k++;
      lcd_cycle_done <= 1'b0;
    end while ((sel ? lcd_cycle_end : suspend_enter) !== 1'b1 && k < 20);
    chk(sel ? "lcd end edges" : "suspend edges", e, k);
  endtask : lat

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk("reset levels", 3'h7, {cpu_clk_run, rom_select_0_n, rom_select_1_n});
    rdchk("one reset", ECR_ADDR_ENH_ONE, ECR_RST_ENH_ONE);
    rdchk("two reset", ECR_ADDR_ENH_TWO, ECR_RST_ENH_TWO);
    rdchk("three reset", ECR_ADDR_ENH_THREE, ECR_RST_ENH_THREE);
    apb(1'b1, ECR_ADDR_ENH_ONE, 8'h7f);
    apb(1'b1, ECR_ADDR_ENH_TWO, 8'h1f);
    wt(2);
    chk("fixes gated", 8'h00, {narrow_card_support, card_change_fix, card_space_fix,
        card_present_fix, wide_dram_fix, psram_oe_fix, ata_timing_relaxed,
        card_mask_ctrl_en});
    rdchk("one back", ECR_ADDR_ENH_ONE, 8'h7f);
    rdchk("two back", ECR_ADDR_ENH_TWO, 8'h1f);
    apb(1'b1, ECR_ADDR_ENH_ONE, 8'h9f);
    wt(2);
    chk("fixes on", 8'hff, {narrow_card_support, card_change_fix, card_space_fix,
        card_present_fix, wide_dram_fix, psram_oe_fix, ata_timing_relaxed,
        card_mask_ctrl_en});
    apb(1'b0, 12'h000, 8'h00);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, ECR_ADDR_ENH_THREE, 8'h1f);
    wt(2);
    chk("bank three gated", 0, arbiter_reset_out);
    apb(1'b1, ECR_ADDR_ENH_THREE, 8'h9f);
    wt(2);
    chk("soft seq on", 6'h3f, {arbiter_reset_out, panel_logic_power_oe, panel_if_enable,
        panel_bias_power_oe, panel_logic_power_out, panel_bias_power_out});
    apb(1'b1, ECR_ADDR_ENH_THREE, 8'h98);
    wt(2);
    chk("soft seq off", 6'h20, {arbiter_reset_out, panel_logic_power_oe, panel_if_enable,
        panel_bias_power_oe, panel_logic_power_out, panel_bias_power_out});
    apb(1'b1, ECR_ADDR_ENH_THREE, 8'ha0);
    baud_clock_out <= 1'b1;
    wt(2);
    chk("baud pin", 2'h3, {gpio_pin_three_out, gpio_pin_three_oe});
    @(posedge clk);
    pm_suspend_state <= 1'b1;
    wt(2);
    chk("pin floats", 0, gpio_pin_three_oe);
    @(posedge clk);
    pm_suspend_state <= 1'b0;
    hw_logic_power <= 1'b1;
    hw_if_enable <= 1'b1;
    hw_bias_power <= 1'b1;
    apb(1'b1, ECR_ADDR_ENH_THREE, 8'hc0);
    lcd_mode_delay_wr <= 1'b1;
    lcd_mode_delay_val <= ECR_PANEL_OFF_CODE;
    @(posedge clk);
    lcd_mode_delay_wr <= 1'b0;
    #1;
    chk("fast off", 3'h0, {panel_logic_power_oe, panel_if_enable, panel_bias_power_oe});
    @(posedge clk);
    lcd_mode_delay_wr <= 1'b1;
    lcd_mode_delay_val <= 3'h3;
    @(posedge clk);
    lcd_mode_delay_wr <= 1'b0;
    #1;
    chk("powerup start", 1, panel_hw_powerup_start);
    wt(2);
    chk("hw powerup", 3'h7, {panel_logic_power_oe, panel_if_enable, panel_bias_power_oe});
    @(posedge clk);
    pm_suspend_req <= 1'b1;
    lat(1'b0, 2);
    pm_suspend_req <= 1'b0;
    apb(1'b1, ECR_ADDR_ENH_ONE, 8'hdf);
    pm_suspend_req <= 1'b1;
    lat(1'b0, SDLY + 2);
    pm_suspend_req <= 1'b0;
    lcd_cycle_done <= 1'b1;
    lat(1'b1, 2);
    apb(1'b1, ECR_ADDR_ENH_ONE, 8'hff);
    lcd_cycle_done <= 1'b1;
    lat(1'b1, 3);
    apb(1'b1, ECR_ADDR_ENH_TWO, 8'h16);
    rom_req_0_n <= 1'b0;
    cpu_data_in <= 16'h5a5a;
    static_doze_mode <= 1'b1;
    pm_doze <= 1'b1;
    wt(4);
    chk("clock held for rom", 1, cpu_clk_run);
    @(posedge clk);
    rom_req_0_n <= 1'b1;
    wt(3);
    chk("doze stop", 3'h3, {cpu_clk_run, rom_select_0_n, rom_select_1_n});
    chk("data gated", 16'h0000, cpu_data_gated);
    @(posedge clk);
    pm_doze <= 1'b0;
    card_cs_active <= 1'b1;
    card_io_width16 <= 1'b1;
    wt(6);
    chk("width early", 0, card_io_width16_sampled);
    chk("doze exit", 17'h15a5a, {cpu_clk_run, cpu_data_gated});
    wt(1);
    chk("width sampled", 1, card_io_width16_sampled);
    // Second reset in mid run clears registers and derived enables
    rst <= 1'b1;
    wt(2);
    chk("mid reset outs", 3'h0, {narrow_card_support, card_io_width16_sampled, cpu_clk_run ^ 1'b1});
    rst <= 1'b0;
    rdchk("one cleared", ECR_ADDR_ENH_ONE, ECR_RST_ENH_ONE);
    rdchk("three cleared", ECR_ADDR_ENH_THREE, ECR_RST_ENH_THREE);
    tally_and_finish;
  end
endmodule : ecr_top_test
`default_nettype wire
